// ===== sfc_params.svh
`ifndef SFC_PARAMS_SVH
`define SFC_PARAMS_SVH

`define SFC_OFF_STATUS 12'h010
`define SFC_OFF_CLEAR 12'h014
`define SFC_OFF_IRQ_MASK 12'h018
`define SFC_OFF_IRQ_STAT 12'h01c

`define SFC_CLEAR_RESET 32'h00000000
`define SFC_MASK_RESET 32'h00000000
`define SFC_FLAG_MASK 32'h3fffffc7
`define SFC_SD_BITS 32'h00c00000

`define SFC_BIT_W_HI_STATE 29
`define SFC_BIT_W_LO_STATE 28
`define SFC_BIT_V_HI_STATE 27
`define SFC_BIT_V_LO_STATE 26
`define SFC_BIT_U_HI_STATE 25
`define SFC_BIT_U_LO_STATE 24
`define SFC_BIT_CONV4_DONE 23
`define SFC_BIT_CONV3_DONE 22
`define SFC_BIT_W_HI_IRQ 21
`define SFC_BIT_W_LO_IRQ 20
`define SFC_BIT_V_HI_IRQ 19
`define SFC_BIT_V_LO_IRQ 18
`define SFC_BIT_U_HI_IRQ 17
`define SFC_BIT_U_LO_IRQ 16
`define SFC_BIT_EXC_SEQ 15
`define SFC_BIT_REF5_OVERLOAD 14
`define SFC_BIT_REF5_OVER 13
`define SFC_BIT_REF5_UNDER 12
`define SFC_BIT_BG_OVER 11
`define SFC_BIT_BG_UNDER 10
`define SFC_BIT_SYS_OT 9
`define SFC_BIT_SYS_OT_WARN 8
`define SFC_BIT_REG_OT 7
`define SFC_BIT_REG_OT_WARN 6
`define SFC_BIT_LIN_OC 0
`define SFC_BIT_LIN_OT 1
`define SFC_BIT_LIN_TMOUT 2
`define SFC_NUM_FLAGS 32

`endif

// ===== sfc_pkg.sv
package sfc_pkg;
    typedef logic [31:0] sfc_word_t;
    typedef enum logic [1:0] {
        SFC_IDLE = 2'b01,
        SFC_DATA = 2'b10
    } sfc_phase_t;
endpackage

// ===== sfc_flag_bank.sv
`timescale 1ns/10ps
`include "sfc_params.svh"
module sfc_flag_bank
    import sfc_pkg::*;
#(
    parameter logic [31:0] IMPL_MASK = `SFC_FLAG_MASK
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [31:0] set_in,
    input wire logic [31:0] clr_in,
    output logic [31:0] flag_q
);
    genvar i;
    generate
        for (i = 0; i < `SFC_NUM_FLAGS; i++) begin : g_flag
            if (IMPL_MASK[i]) begin : g_impl
                // Set beats clear in the same cycle so no event is lost
                always_ff @(posedge clk) begin
                    if (rst) begin
                        flag_q[i] <= 1'b0;
                    end else if (set_in[i]) begin
                        flag_q[i] <= 1'b1;
                    end else if (clr_in[i]) begin
                        flag_q[i] <= 1'b0;
                    end
                end
            end else begin : g_res
                // Absent flags are constant-zero flops, so every bit has one kind of driver
                always_ff @(posedge clk) begin
                    flag_q[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule // sfc_flag_bank

// ===== sfc_irq_gate.sv
`timescale 1ns/10ps
`include "sfc_params.svh"
module sfc_irq_gate
    import sfc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [31:0] stat_in,
    input wire logic [31:0] mask_in,
    output logic irq_q
);
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(stat_in & mask_in);
        end
    end
endmodule // sfc_irq_gate

// ===== sfc_system_flag_clear.sv
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
`include "sfc_params.svh"
// Functional notes
// - clear register resets to all zero under reset type 3.
// - bits 31:30 and 5:3 ignore writes and read zero.
// - ones in bits 29..24 clear zero-crossing status flags W,V,U high/low.
// - bits 23,22 clear converter 4 and 3 done flags, sigma-delta only.
// - ones in bits 21..16 clear zero-crossing interrupt flags.
// - bit 15 clears exceptional sequence interrupt flag.
// - bits 14..12 clear five volt reference overload, over, undervoltage.
// - bits 11,10 clear bandgap over and undervoltage flags.
// - bits 9,8 clear system overtemperature shutdown and prewarning.
// - bits 7,6 clear regulator overtemperature shutdown and prewarning.
// - bits 2..0 clear LIN timeout, overtemperature, overcurrent flags.
// - each clear bit acts on the same bit of the status register.
module sfc_system_flag_clear
    import sfc_pkg::*;
#(
    parameter bit HAS_SIGMA_DELTA = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [31:0] flag_set,
    output logic [31:0] status_q,
    output logic [31:0] clear_pulse_q,
    output logic irq
);
    localparam logic [31:0] IMPL =
        HAS_SIGMA_DELTA ? `SFC_FLAG_MASK : (`SFC_FLAG_MASK & ~`SFC_SD_BITS);

    sfc_phase_t phase_q;
    logic [11:0] addr_q;
    logic wr_q;
    logic [31:0] mask_q;
    logic [31:0] clear_d;
    logic [31:0] flags;
    logic [31:0] rdata_d;
    logic accept;

    // Named clear strobes, one per field, high only in the data phase of a clear write
    logic clr_wr;
    logic phase_w_cross_high_state_clr;
    logic phase_w_cross_low_state_clr;
    logic phase_v_cross_high_state_clr;
    logic phase_v_cross_low_state_clr;
    logic phase_u_cross_high_state_clr;
    logic phase_u_cross_low_state_clr;
    logic conv4_done_irq_clr;
    logic conv3_done_irq_clr;
    logic phase_w_cross_high_irq_clr;
    logic phase_w_cross_low_irq_clr;
    logic phase_v_cross_high_irq_clr;
    logic phase_v_cross_low_irq_clr;
    logic phase_u_cross_high_irq_clr;
    logic phase_u_cross_low_irq_clr;
    logic exceptional_sequence_irq_clr;
    logic ref5_overload_irq_clr;
    logic ref5_overvolt_irq_clr;
    logic ref5_undervolt_irq_clr;
    logic bandgap_overvolt_irq_clr;
    logic bandgap_undervolt_irq_clr;
    logic system_overtemp_irq_clr;
    logic system_overtemp_warn_irq_clr;
    logic regulator_overtemp_irq_clr;
    logic regulator_overtemp_warn_irq_clr;
    logic lin_tx_timeout_clr;
    logic lin_overtemp_clr;
    logic lin_overcurrent_clr;
    logic [31:0] field_clr;

    assign accept = hsel && hready && htrans[1];

    assign clr_wr = (phase_q == SFC_DATA) && wr_q && (addr_q == `SFC_OFF_CLEAR);

    // Zero-crossing status flags
    assign phase_w_cross_high_state_clr = clr_wr && hwdata[`SFC_BIT_W_HI_STATE];
    assign phase_w_cross_low_state_clr = clr_wr && hwdata[`SFC_BIT_W_LO_STATE];
    assign phase_v_cross_high_state_clr = clr_wr && hwdata[`SFC_BIT_V_HI_STATE];
    assign phase_v_cross_low_state_clr = clr_wr && hwdata[`SFC_BIT_V_LO_STATE];
    assign phase_u_cross_high_state_clr = clr_wr && hwdata[`SFC_BIT_U_HI_STATE];
    assign phase_u_cross_low_state_clr = clr_wr && hwdata[`SFC_BIT_U_LO_STATE];

    // Converter done flags; dropped later by IMPL when there is no sigma-delta
    assign conv4_done_irq_clr = clr_wr && hwdata[`SFC_BIT_CONV4_DONE];
    assign conv3_done_irq_clr = clr_wr && hwdata[`SFC_BIT_CONV3_DONE];

    // Zero-crossing interrupt flags
    assign phase_w_cross_high_irq_clr = clr_wr && hwdata[`SFC_BIT_W_HI_IRQ];
    assign phase_w_cross_low_irq_clr = clr_wr && hwdata[`SFC_BIT_W_LO_IRQ];
    assign phase_v_cross_high_irq_clr = clr_wr && hwdata[`SFC_BIT_V_HI_IRQ];
    assign phase_v_cross_low_irq_clr = clr_wr && hwdata[`SFC_BIT_V_LO_IRQ];
    assign phase_u_cross_high_irq_clr = clr_wr && hwdata[`SFC_BIT_U_HI_IRQ];
    assign phase_u_cross_low_irq_clr = clr_wr && hwdata[`SFC_BIT_U_LO_IRQ];

    // Measurement and reference supervision flags
    assign exceptional_sequence_irq_clr = clr_wr && hwdata[`SFC_BIT_EXC_SEQ];
    assign ref5_overload_irq_clr = clr_wr && hwdata[`SFC_BIT_REF5_OVERLOAD];
    assign ref5_overvolt_irq_clr = clr_wr && hwdata[`SFC_BIT_REF5_OVER];
    assign ref5_undervolt_irq_clr = clr_wr && hwdata[`SFC_BIT_REF5_UNDER];
    assign bandgap_overvolt_irq_clr = clr_wr && hwdata[`SFC_BIT_BG_OVER];
    assign bandgap_undervolt_irq_clr = clr_wr && hwdata[`SFC_BIT_BG_UNDER];

    // Temperature flags
    assign system_overtemp_irq_clr = clr_wr && hwdata[`SFC_BIT_SYS_OT];
    assign system_overtemp_warn_irq_clr = clr_wr && hwdata[`SFC_BIT_SYS_OT_WARN];
    assign regulator_overtemp_irq_clr = clr_wr && hwdata[`SFC_BIT_REG_OT];
    assign regulator_overtemp_warn_irq_clr = clr_wr && hwdata[`SFC_BIT_REG_OT_WARN];

    // Transceiver flags
    assign lin_tx_timeout_clr = clr_wr && hwdata[`SFC_BIT_LIN_TMOUT];
    assign lin_overtemp_clr = clr_wr && hwdata[`SFC_BIT_LIN_OT];
    assign lin_overcurrent_clr = clr_wr && hwdata[`SFC_BIT_LIN_OC];

    // Reserved positions are tied low here, so a write of ones there cannot act
    assign field_clr = {
        2'b00,
        phase_w_cross_high_state_clr,
        phase_w_cross_low_state_clr,
        phase_v_cross_high_state_clr,
        phase_v_cross_low_state_clr,
        phase_u_cross_high_state_clr,
        phase_u_cross_low_state_clr,
        conv4_done_irq_clr,
        conv3_done_irq_clr,
        phase_w_cross_high_irq_clr,
        phase_w_cross_low_irq_clr,
        phase_v_cross_high_irq_clr,
        phase_v_cross_low_irq_clr,
        phase_u_cross_high_irq_clr,
        phase_u_cross_low_irq_clr,
        exceptional_sequence_irq_clr,
        ref5_overload_irq_clr,
        ref5_overvolt_irq_clr,
        ref5_undervolt_irq_clr,
        bandgap_overvolt_irq_clr,
        bandgap_undervolt_irq_clr,
        system_overtemp_irq_clr,
        system_overtemp_warn_irq_clr,
        regulator_overtemp_irq_clr,
        regulator_overtemp_warn_irq_clr,
        3'b000,
        lin_tx_timeout_clr,
        lin_overtemp_clr,
        lin_overcurrent_clr
    };

    // Address phase capture; zero wait states
    always_ff @(posedge clk) begin
        if (rst) begin
            phase_q <= SFC_IDLE;
            addr_q <= 12'h000;
            wr_q <= 1'b0;
        end else begin
            phase_q <= accept ? SFC_DATA : SFC_IDLE;
            if (accept) begin
                addr_q <= haddr;
                wr_q <= hwrite;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Clear strobe lasts one cycle, so nothing stays pending
    always_comb begin
        clear_d = `SFC_CLEAR_RESET;
        unique case (phase_q)
            SFC_DATA: begin
                if (wr_q && addr_q == `SFC_OFF_CLEAR) begin
                    clear_d = field_clr & IMPL;
                end
            end
            SFC_IDLE: begin
                clear_d = `SFC_CLEAR_RESET;
            end
        endcase
    end

    // One-shot pulse per written one; zeros cause nothing
    always_ff @(posedge clk) begin
        if (rst) begin
            clear_pulse_q <= `SFC_CLEAR_RESET;
        end else begin
            clear_pulse_q <= clear_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mask_q <= `SFC_MASK_RESET;
        end else if (phase_q == SFC_DATA && wr_q && addr_q == `SFC_OFF_IRQ_MASK) begin
            mask_q <= hwdata & IMPL;
        end
    end

    // Clear is applied combinationally so the flag drops at the edge that ends the data phase
    sfc_flag_bank #(
        .IMPL_MASK(IMPL)
    ) u_bank (
        .clk(clk),
        .rst(rst),
        .set_in(flag_set),
        .clr_in(clear_d),
        .flag_q(flags)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            status_q <= 32'h00000000;
        end else begin
            status_q <= flags;
        end
    end

    sfc_irq_gate u_irq (
        .clk(clk),
        .rst(rst),
        .stat_in(flags),
        .mask_in(mask_q),
        .irq_q(irq)
    );

    // Read data is registered at the address phase so it stands in the data phase
    always_comb begin
        rdata_d = 32'h00000000;
        if (accept && !hwrite) begin
            unique case (haddr)
                `SFC_OFF_STATUS: rdata_d = flags;
                `SFC_OFF_IRQ_MASK: rdata_d = mask_q;
                `SFC_OFF_IRQ_STAT: rdata_d = flags & mask_q;
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata <= 32'h00000000;
        end else begin
            hrdata <= rdata_d;
        end
    end
endmodule // sfc_system_flag_clear

// ===== sfc_system_flag_clear_chk.sv
`timescale 1ns/10ps
module sfc_system_flag_clear_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] flag_set,
    input wire logic [31:0] status_q,
    input wire logic [31:0] clear_pulse_q,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic take, wr_q, rd_q, quiet_q;
    logic [31:0] exp_q;
    assign take = hsel && hready && htrans[1];
    always_ff @(posedge clk) begin
        wr_q <= !rst && take && hwrite && haddr == 12'h014;
        rd_q <= !rst && take && !hwrite && (haddr == 12'h014 || haddr >= 12'h020);
        exp_q <= (wr_q && !rst) ? (hwdata & 32'h3fffffc7) : 32'h0;
        quiet_q <= flag_set == 32'h0;
    end
    rst_zero_a: assert property (disable iff (1'b0) rst |=> status_q == 32'h0 && !irq)
        else $error("outputs not cleared by reset");
    resv_zero_a: assert property ((status_q & 32'hc0000038) == 32'h0)
        else $error("reserved status bit set");
    rd_zero_a: assert property (rd_q |-> hrdata == 32'h0)
        else $error("clear or unmapped read not zero");
    clear_pulse_a: assert property (clear_pulse_q == exp_q)
        else $error("clear pulse differs from written ones");
    // Status output lags the pulse by one cycle, so the pulse is taken one cycle back
    flag_keep_a: assert property (quiet_q && $past(quiet_q) |->
        status_q == ($past(status_q) & ~$past(clear_pulse_q)))
        else $error("flags not cleared as written");
    pulse_once_a: assert property (|clear_pulse_q && !wr_q |=> clear_pulse_q == 32'h0)
        else $error("clear pulse longer than one cycle");
    // Set wins over a clear in the same cycle, so a set must always land
    flag_set_a: assert property (|flag_set |-> ##2 (status_q & $past(flag_set, 2)) ==
        ($past(flag_set, 2) & 32'h3fffffc7))
        else $error("flag not set by source");
    irq_flag_a: assert property (status_q == 32'h0 |-> !irq)
        else $error("interrupt without flag");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
    cover property (wr_q);
    cover property (rd_q);
    cover property (irq ##1 !irq);
endmodule // sfc_system_flag_clear_chk
bind sfc_system_flag_clear sfc_system_flag_clear_chk u_chk (.*);

// ===== sfc_system_flag_clear_tb_top.sv
`timescale 1ns/10ps
module sfc_system_flag_clear_tb_top;
    logic clk = 0, rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp, irq;
    logic [11:0] haddr = 12'h0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, flag_set = 32'h0, hrdata, status_q, clear_pulse_q, r, e;
    int n_errors = 0, compares = 0;
    always #5 clk = ~clk;
    sfc_system_flag_clear DUT (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .flag_set, .status_q,
        .clear_pulse_q, .irq);
    task automatic chk(input logic [31:0] x, g, input string n);
        compares++;
        if (g !== x) begin
            n_errors++;
            $display("BAD %s exp %h got %h", n, x, g);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
        chk(32'h0, 32'(hresp), "hresp");
    endtask
    task automatic pulse_flags(input logic [31:0] f);
        flag_set <= f;
        @(posedge clk);
        flag_set <= 32'h0;
        repeat (3) @(posedge clk);
    endtask
    task automatic t_walk;
        pulse_flags(32'hffffffff);
        e = 32'h3fffffc7;
        bus(1'b1, 12'h018, 32'hffffffff);
        bus(1'b1, 12'h010, 32'h0);
        bus(1'b1, 12'h014, 32'h0);
        for (int i = 0; i < 32; i++) begin
            bus(1'b0, 12'h010, 32'h0);
            chk(e, r, "status");
            chk(32'(e != 32'h0), 32'(irq), "irq");
            // One bit at a time so a swapped field shows up
            bus(1'b1, 12'h014, 32'h1 << i);
            e[i] = 1'b0;
        end
    endtask
    task automatic t_mask;
        pulse_flags(32'h4);
        bus(1'b1, 12'h018, 32'h0);
        repeat (2) @(posedge clk);
        chk(32'h0, 32'(irq), "masked irq");
        bus(1'b1, 12'h018, 32'h4);
        repeat (2) @(posedge clk);
        chk(32'h1, 32'(irq), "irq");
        bus(1'b1, 12'h014, 32'h4);
        repeat (2) @(posedge clk);
        chk(32'h0, 32'(irq), "irq after clear");
        bus(1'b0, 12'h040, 32'h0);
        chk(32'h0, r, "unmapped");
        pulse_flags(32'h3);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, 12'h010, 32'h0);
        chk(32'h0, r, "status after reset");
        bus(1'b0, 12'h014, 32'h0);
        chk(32'h0, r, "clear read");
    endtask
    task automatic end_sim;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_walk;
        t_mask;
        end_sim;
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        end_sim;
    end
endmodule // sfc_system_flag_clear_tb_top
